// ===== hw/fows_cpu.sv
// cpu-side controller: axi4-lite registers driving the wait-state link
`timescale 1ns/1ps
module fows_cpu (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_axi_awvalid,
   output logic o_axi_awready,
   input wire logic [7:0] i_axi_awaddr,
   input wire logic i_axi_wvalid,
   output logic o_axi_wready,
   input wire logic [31:0] i_axi_wdata,
   input wire logic [3:0] i_axi_wstrb,
   output logic o_axi_bvalid,
   input wire logic i_axi_bready,
   output logic [1:0] o_axi_bresp,
   input wire logic i_axi_arvalid,
   output logic o_axi_arready,
   input wire logic [7:0] i_axi_araddr,
   output logic o_axi_rvalid,
   input wire logic i_axi_rready,
   output logic [31:0] o_axi_rdata,
   output logic [1:0] o_axi_rresp,
   fows_if.cpu bus
);
   typedef struct packed {
      fows_pkg::fows_state_t st;
      logic aw_got;
      logic w_got;
      logic is_wr;
      logic [7:0] addr;
      logic [31:0] wdata;
      logic pwe;
      logic reg_req;
      logic reg_wr;
      logic reg_sel;
      logic [15:0] reg_wdata;
      logic rd_req;
      logic rd_otp;
      logic [15:0] rd_addr;
      logic done;
      logic [15:0] rd_data;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } fows_cpu_t;

   fows_cpu_t cpu_reg;
   fows_cpu_t cpu_next;
   logic idle;

   assign idle = (cpu_reg.st == fows_pkg::FOWS_IDLE);
   assign o_axi_awready = idle && !cpu_reg.aw_got;
   assign o_axi_wready = idle && !cpu_reg.w_got;
   // a write half taken blocks later reads; a read offered in the same cycle as it is still taken
   assign o_axi_arready = idle && !cpu_reg.aw_got && !cpu_reg.w_got;

   // ================================================================
   // bus slave and read engine
   always_comb begin
      cpu_next = cpu_reg;
      if (bus.rd_ack) begin
         cpu_next.rd_req = 1'b0;
         cpu_next.done = 1'b1;
         cpu_next.rd_data = bus.rd_data;
      end
      case (cpu_reg.st)
         fows_pkg::FOWS_IDLE: begin
            if (i_axi_awvalid && o_axi_awready) begin
               cpu_next.aw_got = 1'b1;
               cpu_next.addr = i_axi_awaddr;
            end
            if (i_axi_wvalid && o_axi_wready) begin
               cpu_next.w_got = 1'b1;
               cpu_next.wdata = i_axi_wdata;
            end
            if (cpu_reg.aw_got && cpu_reg.w_got) begin
               cpu_next.st = fows_pkg::FOWS_BRESP;
               cpu_next.bvalid = 1'b1;
               cpu_next.bresp = fows_pkg::FOWS_RESP_OKAY;
               cpu_next.is_wr = 1'b1;
               case (cpu_reg.addr)
                  fows_pkg::FOWS_OFS_CTRL: cpu_next.pwe = cpu_reg.wdata[0];
                  fows_pkg::FOWS_OFS_FBW, fows_pkg::FOWS_OFS_OTPW: begin
                     // software owns zero and ordering checks of the values
                     cpu_next.st = fows_pkg::FOWS_REG_WAIT; // R3 R4 R9 R13
                     cpu_next.bvalid = 1'b0;
                     cpu_next.reg_req = 1'b1;
                     cpu_next.reg_wr = 1'b1;
                     cpu_next.reg_sel = (cpu_reg.addr == fows_pkg::FOWS_OFS_OTPW);
                     cpu_next.reg_wdata = cpu_reg.wdata[15:0];
                  end
                  fows_pkg::FOWS_OFS_CMD: begin
                     // a command while one is running is dropped
                     if (!cpu_reg.rd_req) begin
                        cpu_next.rd_req = 1'b1;
                        cpu_next.done = 1'b0;
                        cpu_next.rd_addr = cpu_reg.wdata[15:0];
                        cpu_next.rd_otp = cpu_reg.wdata[fows_pkg::FOWS_CMD_OTP_BIT];
                     end
                  end
                  fows_pkg::FOWS_OFS_STAT: cpu_next.bresp = fows_pkg::FOWS_RESP_OKAY;
                  default: cpu_next.bresp = fows_pkg::FOWS_RESP_SLVERR;
               endcase
            end else if (i_axi_arvalid && o_axi_arready) begin
               cpu_next.st = fows_pkg::FOWS_RRESP;
               cpu_next.rvalid = 1'b1;
               cpu_next.rresp = fows_pkg::FOWS_RESP_OKAY;
               cpu_next.rdata = 32'h0000_0000;
               cpu_next.is_wr = 1'b0;
               case (i_axi_araddr)
                  fows_pkg::FOWS_OFS_CTRL: cpu_next.rdata[0] = cpu_reg.pwe;
                  fows_pkg::FOWS_OFS_FBW, fows_pkg::FOWS_OFS_OTPW: begin
                     cpu_next.st = fows_pkg::FOWS_REG_WAIT;
                     cpu_next.rvalid = 1'b0;
                     cpu_next.reg_req = 1'b1;
                     cpu_next.reg_wr = 1'b0;
                     cpu_next.reg_sel = (i_axi_araddr == fows_pkg::FOWS_OFS_OTPW);
                  end
                  fows_pkg::FOWS_OFS_CMD:
                     cpu_next.rdata = {15'h0000, cpu_reg.rd_otp, cpu_reg.rd_addr};
                  fows_pkg::FOWS_OFS_STAT:
                     cpu_next.rdata = {cpu_reg.rd_data, 14'h0000, cpu_reg.done, cpu_reg.rd_req};
                  default: cpu_next.rresp = fows_pkg::FOWS_RESP_SLVERR;
               endcase
            end
         end
         fows_pkg::FOWS_REG_WAIT: begin
            if (bus.reg_ack) begin
               cpu_next.reg_req = 1'b0;
               if (cpu_reg.is_wr) begin
                  cpu_next.st = fows_pkg::FOWS_BRESP;
                  cpu_next.bvalid = 1'b1;
               end else begin
                  cpu_next.st = fows_pkg::FOWS_RRESP;
                  cpu_next.rvalid = 1'b1;
                  cpu_next.rdata = {16'h0000, bus.reg_rdata};
               end
            end
         end
         fows_pkg::FOWS_BRESP: begin
            if (i_axi_bready) begin
               cpu_next.bvalid = 1'b0;
               cpu_next.aw_got = 1'b0;
               cpu_next.w_got = 1'b0;
               cpu_next.st = fows_pkg::FOWS_IDLE;
            end
         end
         fows_pkg::FOWS_RRESP: begin
            if (i_axi_rready) begin
               cpu_next.rvalid = 1'b0;
               cpu_next.st = fows_pkg::FOWS_IDLE;
            end
         end
         default: cpu_next.st = fows_pkg::FOWS_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         cpu_reg <= '0;
      end else begin
         cpu_reg <= cpu_next;
      end
   end

   // ================================================================
   // outputs
   assign o_axi_bvalid = cpu_reg.bvalid;
   assign o_axi_bresp = cpu_reg.bresp;
   assign o_axi_rvalid = cpu_reg.rvalid;
   assign o_axi_rdata = cpu_reg.rdata;
   assign o_axi_rresp = cpu_reg.rresp;
   assign bus.pwe = cpu_reg.pwe;
   assign bus.reg_req = cpu_reg.reg_req;
   assign bus.reg_wr = cpu_reg.reg_wr;
   assign bus.reg_sel = cpu_reg.reg_sel;
   assign bus.reg_wdata = cpu_reg.reg_wdata;
   assign bus.rd_req = cpu_reg.rd_req;
   assign bus.rd_otp = cpu_reg.rd_otp;
   assign bus.rd_addr = cpu_reg.rd_addr;
endmodule

// ===== hw/fows_pkg.sv
// constants and types shared by the flash/otp wait-state ends
// ================================================================
// Behaviour
// R1: random wait in bits 3-0, wait+1 cycles
// R2: random wait resets to fifteen, sixteen cycles
// R3: software never writes random wait zero
// R4: software keeps random wait >= paged wait
// R5: counts applied as written, never corrected
// R6: software writes reserved bits zero; read zero
// R7: otp wait in bits 4-0, wait+1 cycles
// R8: otp reads never paged, always otp count
// R9: software never writes otp wait zero
// R10: otp wait resets to 31, 32 cycles
// R11: wait writes need protected write enable
// R12: wait writes need unsecured security state
// R13: software follows the wait update sequence
// R14: paged wait in bits 11-8, resets fifteen
// R15: read stalls on wait counter, then returns
package fows_pkg;
   // ================================================================
   // wait register select on the link
   localparam logic FOWS_SEL_FLASH = 1'b0;
   localparam logic FOWS_SEL_OTP = 1'b1;
   // ================================================================
   // field positions and widths
   localparam int FOWS_RAND_LSB = 0;
   localparam int FOWS_RAND_W = 4;
   localparam int FOWS_PAGE_LSB = 8;
   localparam int FOWS_PAGE_W = 4;
   localparam int FOWS_OTP_LSB = 0;
   localparam int FOWS_OTP_W = 5;
   localparam int FOWS_CNT_W = 5;
   // ================================================================
   // values after reset
   localparam logic [3:0] FOWS_RAND_RST = 4'hf;
   localparam logic [3:0] FOWS_PAGE_RST = 4'hf;
   localparam logic [4:0] FOWS_OTP_RST = 5'h1f;
   // ================================================================
   // controller register offsets (byte addresses)
   localparam logic [7:0] FOWS_OFS_CTRL = 8'h00;
   localparam logic [7:0] FOWS_OFS_FBW = 8'h04;
   localparam logic [7:0] FOWS_OFS_OTPW = 8'h08;
   localparam logic [7:0] FOWS_OFS_CMD = 8'h0c;
   localparam logic [7:0] FOWS_OFS_STAT = 8'h10;
   localparam int FOWS_CMD_OTP_BIT = 16;
   localparam logic [1:0] FOWS_RESP_OKAY = 2'b00;
   localparam logic [1:0] FOWS_RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {FOWS_IDLE, FOWS_REG_WAIT, FOWS_BRESP, FOWS_RRESP} fows_state_t;
endpackage

// ===== hw/fows_if.sv
// link between the cpu-side controller and the wait-state device
`timescale 1ns/1ps
interface fows_if;
   logic pwe;
   logic reg_req;
   logic reg_wr;
   logic reg_sel;
   logic [15:0] reg_wdata;
   logic reg_ack;
   logic [15:0] reg_rdata;
   logic rd_req;
   logic rd_otp;
   logic [15:0] rd_addr;
   logic rd_ack;
   logic [15:0] rd_data;
   modport dev (
      input pwe, reg_req, reg_wr, reg_sel, reg_wdata, rd_req, rd_otp, rd_addr,
      output reg_ack, reg_rdata, rd_ack, rd_data
   );
   modport cpu (
      output pwe, reg_req, reg_wr, reg_sel, reg_wdata, rd_req, rd_otp, rd_addr,
      input reg_ack, reg_rdata, rd_ack, rd_data
   );
endinterface

// ===== hw/fows_wait_cnt.sv
// loadable down counter that paces one array access
`timescale 1ns/1ps
module fows_wait_cnt #(
   parameter int W = 5
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [W-1:0] i_load_val,
   output logic o_zero
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } fows_cnt_t;
   fows_cnt_t cnt_reg;
   fows_cnt_t cnt_next;

   // ================================================================
   // count
   always_comb begin
      cnt_next = cnt_reg;
      if (i_load) begin
         cnt_next.cnt = i_load_val;
      end else if (cnt_reg.cnt != '0) begin
         cnt_next.cnt = cnt_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign o_zero = (cnt_reg.cnt == '0);
endmodule

// ===== hw/fows_dev.sv
// flash and otp wait-state device: wait registers and read pacing
`timescale 1ns/1ps
module fows_dev #(
   parameter int PAGE_ADDR_BITS = 3
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   fows_if.dev bus,
   input wire logic i_unsecured,
   input wire logic [15:0] i_flash_data,
   input wire logic [15:0] i_otp_data,
   output logic [15:0] o_array_addr,
   output logic o_array_en,
   output logic o_array_otp
);
   localparam int TAG_W = 16 - PAGE_ADDR_BITS;

   typedef struct packed {
      logic [3:0] rand_wait;
      logic [3:0] page_wait;
      logic [4:0] otp_wait;
      logic reg_ack;
      logic [15:0] reg_rdata;
      logic busy;
      logic otp_sel;
      logic [15:0] addr;
      logic page_valid;
      logic [TAG_W-1:0] page_tag;
      logic rd_ack;
      logic [15:0] rd_data;
   } fows_dev_t;

   fows_dev_t dev_reg;
   fows_dev_t dev_next;

   logic take_rd;
   logic page_hit;
   logic [fows_pkg::FOWS_CNT_W-1:0] load_val;
   logic cnt_zero;
   logic [15:0] flash_view;
   logic [15:0] otp_view;
   logic wr_allowed;

   // ================================================================
   // read-back views, reserved bits forced low
   always_comb begin
      flash_view = 16'h0000;
      flash_view[fows_pkg::FOWS_RAND_LSB +: fows_pkg::FOWS_RAND_W] = dev_reg.rand_wait; // R6
      flash_view[fows_pkg::FOWS_PAGE_LSB +: fows_pkg::FOWS_PAGE_W] = dev_reg.page_wait;
      otp_view = 16'h0000;
      otp_view[fows_pkg::FOWS_OTP_LSB +: fows_pkg::FOWS_OTP_W] = dev_reg.otp_wait; // R6
   end

   // both gates must hold; a blocked write still answers so the bus never hangs
   assign wr_allowed = bus.pwe && i_unsecured; // R11 R12

   // ================================================================
   // wait count selection
   assign take_rd = !dev_reg.busy && bus.rd_req && !dev_reg.rd_ack;
   assign page_hit = dev_reg.page_valid
                     && (bus.rd_addr[15:PAGE_ADDR_BITS] == dev_reg.page_tag);

   always_comb begin
      if (bus.rd_otp) begin
         load_val = dev_reg.otp_wait; // R7 R8
      end else if (page_hit) begin
         load_val = {1'b0, dev_reg.page_wait}; // R14
      end else begin
         load_val = {1'b0, dev_reg.rand_wait}; // R1
      end
   end

   // no comparison of paged against random: a bad pair runs as programmed
   fows_wait_cnt #(
      .W(fows_pkg::FOWS_CNT_W)
   ) u_cnt (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_load(take_rd),
      .i_load_val(load_val),
      .o_zero(cnt_zero)
   ); // R5

   // ================================================================
   // register access and read sequencing
   always_comb begin
      dev_next = dev_reg;
      dev_next.reg_ack = 1'b0;
      dev_next.rd_ack = 1'b0;

      if (bus.reg_req && !dev_reg.reg_ack) begin
         dev_next.reg_ack = 1'b1;
         dev_next.reg_rdata = 16'h0000;
         if (bus.reg_wr) begin
            if (wr_allowed) begin // R11 R12
               if (bus.reg_sel == fows_pkg::FOWS_SEL_FLASH) begin
                  // zero is stored as written; software must avoid it
                  dev_next.rand_wait =
                     bus.reg_wdata[fows_pkg::FOWS_RAND_LSB +: fows_pkg::FOWS_RAND_W]; // R1 R5
                  dev_next.page_wait =
                     bus.reg_wdata[fows_pkg::FOWS_PAGE_LSB +: fows_pkg::FOWS_PAGE_W]; // R14
               end else begin
                  dev_next.otp_wait =
                     bus.reg_wdata[fows_pkg::FOWS_OTP_LSB +: fows_pkg::FOWS_OTP_W]; // R7
               end
            end
         end else if (i_unsecured) begin
            // a secured device reads the wait registers as zero
            if (bus.reg_sel == fows_pkg::FOWS_SEL_FLASH) begin
               dev_next.reg_rdata = flash_view;
            end else begin
               dev_next.reg_rdata = otp_view;
            end
         end
      end

      if (take_rd) begin
         dev_next.busy = 1'b1; // R15
         dev_next.otp_sel = bus.rd_otp;
         dev_next.addr = bus.rd_addr;
         if (!bus.rd_otp) begin
            // otp has no page mode and leaves the flash page tag alone
            dev_next.page_valid = 1'b1; // R8
            dev_next.page_tag = bus.rd_addr[15:PAGE_ADDR_BITS];
         end
      end else if (dev_reg.busy && cnt_zero) begin
         dev_next.busy = 1'b0; // R15
         dev_next.rd_ack = 1'b1;
         if (dev_reg.otp_sel) begin
            dev_next.rd_data = i_otp_data;
         end else begin
            dev_next.rd_data = i_flash_data;
         end
      end
   end

   // ================================================================
   // state register
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         dev_reg <= '0;
         dev_reg.rand_wait <= fows_pkg::FOWS_RAND_RST; // R2
         dev_reg.page_wait <= fows_pkg::FOWS_PAGE_RST; // R14
         dev_reg.otp_wait <= fows_pkg::FOWS_OTP_RST; // R10
      end else begin
         dev_reg <= dev_next;
      end
   end

   // ================================================================
   // outputs
   assign bus.reg_ack = dev_reg.reg_ack;
   assign bus.reg_rdata = dev_reg.reg_rdata;
   assign bus.rd_ack = dev_reg.rd_ack;
   assign bus.rd_data = dev_reg.rd_data;
   assign o_array_addr = dev_reg.addr;
   assign o_array_en = dev_reg.busy;
   assign o_array_otp = dev_reg.otp_sel;
endmodule

// ===== tb/fows_properties.sv
// concurrent checks on the wait-state link
`timescale 1ns/1ps
module fows_properties #(
   parameter int PAGE_ADDR_BITS = 3
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_unsecured,
   input wire logic pwe,
   input wire logic reg_req,
   input wire logic reg_wr,
   input wire logic reg_sel,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_ack,
   input wire logic [15:0] reg_rdata,
   input wire logic rd_req,
   input wire logic rd_otp,
   input wire logic [15:0] rd_addr,
   input wire logic rd_ack,
   input wire logic [15:0] rd_data
);
   // ================
   // shadow of wait fields and read pacing
   logic [3:0] rand_reg;
   logic [3:0] page_reg;
   logic [4:0] otp_reg;
   logic [15:0] tag_reg;
   logic tag_ok_reg;
   logic busy_reg;
   logic [5:0] cnt_reg;
   logic [4:0] wsel_reg;
   logic start;
   logic wr_ok;
   logic [4:0] w_now;
   assign start = rd_req && !busy_reg && !rd_ack;
   assign wr_ok = reg_req && !reg_ack && reg_wr && pwe && i_unsecured;
   // otp reads never hit the page tag
   assign w_now = rd_otp ? otp_reg :
      (tag_ok_reg && tag_reg == (rd_addr >> PAGE_ADDR_BITS)) ? {1'b0, page_reg} : {1'b0, rand_reg};
   always_ff @(posedge i_ref_clk) begin
      if (!i_nrst) begin
         rand_reg <= 4'hf;
         page_reg <= 4'hf;
         otp_reg <= 5'h1f;
         tag_reg <= 16'h0;
         tag_ok_reg <= 1'b0;
         busy_reg <= 1'b0;
         cnt_reg <= 6'h0;
         wsel_reg <= 5'h0;
      end else begin
         if (wr_ok && reg_sel) begin
            otp_reg <= reg_wdata[4:0];
         end
         if (wr_ok && !reg_sel) begin
            rand_reg <= reg_wdata[3:0];
            page_reg <= reg_wdata[11:8];
         end
         if (start) begin
            busy_reg <= 1'b1;
            cnt_reg <= 6'h1;
            wsel_reg <= w_now;
            if (!rd_otp) begin
               tag_reg <= rd_addr >> PAGE_ADDR_BITS;
               tag_ok_reg <= 1'b1;
            end
         end else if (busy_reg) begin
            cnt_reg <= cnt_reg + 6'h1;
            if (rd_ack) begin
               busy_reg <= 1'b0;
            end
         end
      end
   end
   // ================
   // properties
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_reg_take;
      reg_req && !reg_ack;
   endsequence
   sequence s_ack_pulse;
      reg_ack ##1 !reg_ack;
   endsequence
   a_reg_ack_next: assert property (s_reg_take |=> s_ack_pulse)
      else $error("link register ack not one cycle after take");
   a_ack_after_req: assert property (reg_ack |-> $past(reg_req))
      else $error("link register ack without request");
   a_reg_read_value: assert property (
      reg_ack && !reg_wr |-> reg_rdata == (!i_unsecured ? 16'h0 :
      reg_sel ? {11'h0, otp_reg} : {4'h0, page_reg, 4'h0, rand_reg}))
      else $error("wait register read value wrong");
   // ack lands one past the last enabled cycle, so count plus two
   a_rd_timing: assert property (
      busy_reg |-> rd_ack == (cnt_reg == {1'b0, wsel_reg} + 6'd2))
      else $error("array read ack at wrong cycle");
   a_rd_no_spur: assert property (!busy_reg |-> !rd_ack)
      else $error("array ack with no read running");
   a_rd_not_early: assert property (start |=> !rd_ack)
      else $error("array ack right after take");
   a_rd_ack_pulse: assert property (rd_ack |=> !rd_ack)
      else $error("array ack longer than one cycle");
   a_rd_req_held: assert property (rd_ack |-> rd_req)
      else $error("array ack after request dropped");
endmodule

// ===== tb/flash_otp_wait_state_control_bench.sv
// bench joining controller and wait-state device over the link
`timescale 1ns/1ps
module flash_otp_wait_state_control_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic unsec = 1'b1;
   logic [15:0] fl_data = 16'hc3a5;
   logic [15:0] otp_data = 16'h5a3c;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, en, arr_otp;
   logic [15:0] arr_addr;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int err_count = 0, n_compared = 0, en_cnt = 0;
   fows_if link ();
   always #4 clk = ~clk;
   always @(posedge clk) if (en === 1'b1) en_cnt <= en_cnt + 1;
   fows_dev #(.PAGE_ADDR_BITS(3)) fows_dev_i (.i_ref_clk(clk), .i_nrst(nrst), .bus(link.dev),
      .i_unsecured(unsec), .i_flash_data(fl_data), .i_otp_data(otp_data),
      .o_array_addr(arr_addr), .o_array_en(en), .o_array_otp(arr_otp));
   fows_cpu fows_cpu_i (.i_ref_clk(clk), .i_nrst(nrst), .i_axi_awvalid(awvalid),
      .o_axi_awready(awready), .i_axi_awaddr(awaddr), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
      .i_axi_wdata(wdata), .i_axi_wstrb(4'hf), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
      .o_axi_bresp(bresp), .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
      .o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
      .bus(link.cpu));
   fows_properties #(.PAGE_ADDR_BITS(3)) fows_properties_i (.i_ref_clk(clk), .i_nrst(nrst),
      .i_unsecured(unsec), .pwe(link.pwe), .reg_req(link.reg_req), .reg_wr(link.reg_wr),
      .reg_sel(link.reg_sel), .reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack),
      .reg_rdata(link.reg_rdata), .rd_req(link.rd_req), .rd_otp(link.rd_otp),
      .rd_addr(link.rd_addr), .rd_ack(link.rd_ack), .rd_data(link.rd_data));
   // ================
   // shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // readys sampled at the falling edge, so no race with the rising-edge flops
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hit, w_hit, b_hit;
      b_hit = 1'b0;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!b_hit) begin
         @(negedge clk);
         aw_hit = awvalid & awready;
         w_hit = wvalid & wready;
         b_hit = bvalid & bready;
         r = bresp;
         @(posedge clk);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hit, r_hit;
      r_hit = 1'b0;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (!r_hit) begin
         @(negedge clk);
         ar_hit = arvalid & arready;
         r_hit = rvalid & rready;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_hit) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      check({30'h0, r}, {30'h0, fows_pkg::FOWS_RESP_OKAY});
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      check(d, exp);
      check({30'h0, r}, {30'h0, fows_pkg::FOWS_RESP_OKAY});
   endtask
   task automatic arr_rd(input logic [15:0] a, input logic otp, input int w);
      logic [31:0] d;
      logic [1:0] r;
      en_cnt = 0;
      wr(fows_pkg::FOWS_OFS_CMD, {15'h0, otp, a});
      d = 32'h0;
      while (d[1] !== 1'b1) axi_rd(fows_pkg::FOWS_OFS_STAT, d, r);
      check(32'(en_cnt), 32'(w + 1));
      check({16'h0, d[31:16]}, {16'h0, otp ? otp_data : fl_data});
      check({16'h0, arr_addr}, {16'h0, a});
      check({31'h0, arr_otp}, {31'h0, otp});
   endtask
   // ================
   // scenarios
   task automatic test_reset;
      rd_chk(fows_pkg::FOWS_OFS_FBW, 32'h0f0f);
      rd_chk(fows_pkg::FOWS_OFS_OTPW, 32'h001f);
      arr_rd(16'h0010, 1'b0, 15);
      arr_rd(16'h0010, 1'b1, 31);
      $display("test reset done");
   endtask
   task automatic test_protect;
      wr(fows_pkg::FOWS_OFS_CTRL, 32'h0);
      wr(fows_pkg::FOWS_OFS_FBW, 32'h0101);
      rd_chk(fows_pkg::FOWS_OFS_FBW, 32'h0f0f);
      wr(fows_pkg::FOWS_OFS_CTRL, 32'h1);
      @(posedge clk);
      unsec <= 1'b0;
      wr(fows_pkg::FOWS_OFS_OTPW, 32'h0003);
      rd_chk(fows_pkg::FOWS_OFS_OTPW, 32'h0);
      @(posedge clk);
      unsec <= 1'b1;
      rd_chk(fows_pkg::FOWS_OFS_OTPW, 32'h001f);
      $display("test protect done");
   endtask
   task automatic test_fields;
      // software side keeps reserved bits zero and paged not above random
      wr(fows_pkg::FOWS_OFS_FBW, 32'h0000_0305);
      rd_chk(fows_pkg::FOWS_OFS_FBW, 32'h0305);
      wr(fows_pkg::FOWS_OFS_OTPW, 32'h0000_0002);
      rd_chk(fows_pkg::FOWS_OFS_OTPW, 32'h0002);
      $display("test fields done");
   endtask
   task automatic test_timing;
      arr_rd(16'h0040, 1'b0, 5);
      arr_rd(16'h0045, 1'b0, 3);
      arr_rd(16'h0048, 1'b0, 5);
      arr_rd(16'h0049, 1'b1, 2);
      arr_rd(16'h0050, 1'b1, 2);
      arr_rd(16'h004a, 1'b0, 3);
      wr(fows_pkg::FOWS_OFS_FBW, 32'h0000_0001);
      arr_rd(16'h0100, 1'b0, 1);
      arr_rd(16'h0101, 1'b0, 0);
      $display("test timing done");
   endtask
   task automatic test_unmapped;
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(8'h14, 32'h1, r);
      check({30'h0, r}, {30'h0, fows_pkg::FOWS_RESP_SLVERR});
      axi_rd(8'h14, d, r);
      check({30'h0, r}, {30'h0, fows_pkg::FOWS_RESP_SLVERR});
      $display("test unmapped done");
   endtask
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      test_reset();
      test_protect();
      test_fields();
      test_timing();
      test_unmapped();
      test_done();
   end
   // whole run needs a few hundred cycles; this allows far more
   initial begin
      #200000;
      err_count++;
      test_done();
   end
endmodule
